// file: pkg/dcl_mem_if.sv
// Purpose: Port bundle between the control top and its register store
// Assumes: One clock domain
// Notes:   Write and read ports of a small word memory
`timescale 1ns/1ps
`include "dcl_params.svh"
interface dcl_mem_if;
  logic                   we;
  logic [`DCL_ADDR_W-1:0] waddr;
  logic [31:0]            wdata;
  logic [`DCL_ADDR_W-1:0] raddr;
  logic [31:0]            rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : dcl_mem_if

// file: pkg/dcl_params.svh
// Purpose: Offsets, field positions, reset values and timing counts for chip control
// Assumes: 32-bit register words, word addresses
// Notes:   Included by bare name; definitions only
`ifndef DCL_PARAMS_SVH
`define DCL_PARAMS_SVH

`define DCL_ADDR_W          4
`define DCL_NREG            4
// Register indices (word addresses)
`define DCL_REG_FUNC_ONE    4'h0
`define DCL_REG_CLOCK       4'h1
`define DCL_REG_PWR         4'h2
`define DCL_REG_STATUS      4'h3
// Function register one fields
`define DCL_F1_PPC_LO       12
`define DCL_F1_PPC_HI       14
`define DCL_F1_RAMP_LO      8
`define DCL_F1_RAMP_HI      9
`define DCL_F1_LEVEL_LO     4
`define DCL_F1_LEVEL_HI     5
`define DCL_F1_AUTO_PH      0
`define DCL_F1_AUTO_SW      1
`define DCL_F1_CLR_PH       2
`define DCL_F1_CLR_SW       3
// Clock register fields
`define DCL_CK_MULT_LO      0
`define DCL_CK_MULT_HI      4
`define DCL_CK_PUMP_LO      8
`define DCL_CK_PUMP_HI      9
`define DCL_CK_GAIN         12
// Power register fields
`define DCL_PW_CLKIN        0
`define DCL_PW_DACREF       1
`define DCL_PW_SYNCOUT      2
`define DCL_PW_FULLMODE     4
// Status register fields
`define DCL_ST_MULT_ON      0
`define DCL_ST_MULT_BAD     1
`define DCL_ST_PD_DIG       2
`define DCL_ST_PD_ALL       3
`define DCL_ST_FACT_LO      8
`define DCL_ST_FACT_HI      12
// Limits and reset values
`define DCL_MULT_MIN        5'h04
`define DCL_MULT_MAX        5'h14
`define DCL_PUMP_75UA       2'h0
`define DCL_RST_WORD        32'h0000_0000
`define DCL_FACT_ONE        5'h01
`define DCL_MULT_OFF        5'h00
// Commit walk steps: function word staged, then clock word and apply
`define DCL_CMT_F1          2'h1
`define DCL_CMT_LAST        2'h2
`endif

// file: pkg/dcl_pkg.sv
// Purpose: Types shared by the chip control files
// Assumes: dcl_params.svh supplies the numbers
// Notes:   Nothing is imported; refer as dcl_pkg::name
package dcl_pkg;
  typedef enum logic [1:0] {
    DCL_RAMP_OFF   = 2'b00,
    DCL_RAMP_P23   = 2'b01,
    DCL_RAMP_P3    = 2'b10,
    DCL_RAMP_SDIO  = 2'b11
  } dcl_ramp_t;

  typedef enum logic [1:0] {
    DCL_LVL_2  = 2'b00,
    DCL_LVL_4  = 2'b01,
    DCL_LVL_8  = 2'b10,
    DCL_LVL_16 = 2'b11
  } dcl_level_t;

  typedef enum logic [1:0] {
    DCL_PS_UP   = 2'b00,
    DCL_PS_DIG  = 2'b01,
    DCL_PS_FULL = 2'b10
  } dcl_pstate_t;
endpackage : dcl_pkg

// file: tb/dcl_chip_ctrl_props.sv
// Purpose: Port-level checks for the chip control top
// Assumes: One clock, sync active-low reset
// Notes:   Bound after endmodule
`timescale 1ns/1ps
`include "dcl_params.svh"
module dcl_chip_ctrl_props (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  rd_stb,
  input wire logic [31:0]           rdata,
  input wire logic                  io_update,
  input wire logic                  powerdown_input,
  input wire logic                  mult_enable,
  input wire logic [4:0]            mult_factor,
  input wire logic [1:0]            pump_current_select,
  input wire logic                  oscillator_gain_range,
  input wire logic [2:0]            profile_pin_config_bits,
  input dcl_pkg::dcl_ramp_t         amplitude_ramp_control,
  input dcl_pkg::dcl_level_t        mod_level,
  input wire logic                  phase_acc_clear,
  input wire logic                  pd_clock_input,
  input wire logic                  pd_dac_ref,
  input wire logic                  pd_sync_clock_output,
  input wire logic                  pd_digital,
  input wire logic                  pd_all
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Field outputs move on the sixth sampled edge after a taken strobe
  wire logic [14:0] fields_w = {profile_pin_config_bits, amplitude_ramp_control, mod_level,
                                mult_factor, pump_current_select, oscillator_gain_range};
  wire logic [2:0]  swpd_w   = {pd_clock_input, pd_dac_ref, pd_sync_clock_output};
  sequence commit_6;
    $past(io_update, 6) && !$past(io_update, 7);
  endsequence
  // A held clear drops only after a later commit
  sequence clr_drop;
    phase_acc_clear [*2] ##1 !phase_acc_clear;
  endsequence
  chk_commit_timing: assert property ($changed(fields_w) |-> commit_6)
    else $error("Field outputs moved without a commit");
  chk_swpd_commit: assert property ($changed(swpd_w) |-> commit_6)
    else $error("Software power-down moved without a commit");
  chk_read_window: assert property (!$past(rd_stb) |-> rdata == 32'h0000_0000)
    else $error("Read data outside its cycle");
  chk_bypass_one: assert property (!mult_enable |-> mult_factor == 5'h01)
    else $error("Bypass factor is not one");
  chk_factor_range: assert property (mult_enable |-> mult_factor inside {[5'h04:5'h14]})
    else $error("Factor out of range");
  chk_gain_mult: assert property (oscillator_gain_range |-> mult_enable)
    else $error("Gain set with multiplier bypassed");
  chk_pin_follow: assert property (pd_digital == $past(powerdown_input))
    else $error("Digital power-down does not follow pin");
  chk_full_needs_pin: assert property (pd_all |-> pd_digital)
    else $error("Full power-down without pin request");
  chk_clear_hold: assert property (clr_drop |-> $past(io_update, 5) || $past(io_update, 6)
                                   || $past(io_update, 7))
    else $error("Clear released without a commit");
endmodule : dcl_chip_ctrl_props
bind dcl_chip_ctrl dcl_chip_ctrl_props u_props (.clk, .reset_n, .rd_stb, .rdata, .io_update,
  .powerdown_input, .mult_enable, .mult_factor, .pump_current_select, .oscillator_gain_range,
  .profile_pin_config_bits, .amplitude_ramp_control, .mod_level, .phase_acc_clear,
  .pd_clock_input, .pd_dac_ref, .pd_sync_clock_output, .pd_digital, .pd_all);

// file: tb/dcl_host_model.sv
// Purpose: Host side: register port, update strobe, power-down pin
// Assumes: Signals change by NBA just after a rising edge
// Notes:   Released write data are inverted so stale values never match
`timescale 1ns/1ps
`include "dcl_params.svh"
module dcl_host_model (
  input  wire logic                   clk,
  input  wire logic [31:0]            rdata,
  output logic      [`DCL_ADDR_W-1:0] addr,
  output logic      [31:0]            wdata,
  output logic                        wr_stb,
  output logic                        rd_stb,
  output logic                        io_update,
  output logic                        powerdown_input
);
  // Idle levels from time zero
  initial
  begin
    addr = 4'h0;
    wdata = 32'h0000_0000;
    {wr_stb, rd_stb, io_update, powerdown_input} = 4'h0;
  end
  // One-cycle write; gain bit chosen by caller when multiplying high
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask : wr
  // One-cycle read, data taken in the following cycle only
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd
  // Update strobe, one cycle high
  task upd;
    @(posedge clk);
    io_update <= 1'b1;
    @(posedge clk);
    io_update <= 1'b0;
  endtask : upd
  // High requests power-down, low power-up
  task pin(input logic v);
    @(posedge clk);
    powerdown_input <= v;
  endtask : pin
endmodule : dcl_host_model

// file: tb/test_dds_chip_level_control.sv
// Purpose: Self-checking bench for the chip control block
// Assumes: Host model drives all bus and pin inputs
// Notes:   Commit waits use the fixed latency of the hand-over
`timescale 1ns/1ps
`include "dcl_params.svh"
module test_dds_chip_level_control;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic wr_stb, rd_stb, io_update, powerdown_input, mult_enable, oscillator_gain_range;
  logic [4:0] mult_factor;
  logic [1:0] pump_current_select;
  logic [2:0] profile_pin_config_bits;
  dcl_pkg::dcl_ramp_t amplitude_ramp_control;
  dcl_pkg::dcl_level_t mod_level;
  logic phase_acc_clear, sweep_acc_clear, pd_clock_input, pd_dac_ref, pd_sync_clock_output;
  logic pd_digital, pd_all;
  int n_errors = 0;
  int checks_done = 0;
  localparam logic [4:0] FIN [5] = '{5'h00, 5'h04, 5'h14, 5'h03, 5'h19};
  localparam logic [4:0] FEX [5] = '{5'h01, 5'h04, 5'h14, 5'h04, 5'h14};
  // 200 MHz clock
  always #2.5 clk = ~clk;
  dcl_host_model u_host (.clk, .rdata, .addr, .wdata, .wr_stb, .rd_stb, .io_update,
                         .powerdown_input);
  dcl_chip_ctrl u_dut (.clk, .reset_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .io_update,
    .powerdown_input, .mult_enable, .mult_factor, .pump_current_select,
    .oscillator_gain_range, .profile_pin_config_bits, .amplitude_ramp_control, .mod_level,
    .phase_acc_clear, .sweep_acc_clear, .pd_clock_input, .pd_dac_ref,
    .pd_sync_clock_output, .pd_digital, .pd_all);
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task t_reset;
    check("factor", 32'(mult_factor), 32'h1);
    check("pump", 32'(pump_current_select), 32'(`DCL_PUMP_75UA));
    check("ppc", 32'(profile_pin_config_bits), 32'h0);
    check("ramp", 32'(amplitude_ramp_control), 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task t_func;
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(`DCL_REG_FUNC_ONE, (32'(i + 4) << 12) | (32'(i) << 8) | (32'(i) << 4));
      cyc(2);
      check("ppc held", 32'(profile_pin_config_bits), i == 0 ? 32'h0 : 32'(i + 3));
      u_host.upd();
      cyc(6);
      check("ppc", 32'(profile_pin_config_bits), 32'(i + 4));
      check("ramp", 32'(amplitude_ramp_control), 32'(i));
      check("level", 32'(mod_level), 32'(i));
    end
    $display("t_func done");
  endtask : t_func
  task t_clock;
    for (int i = 0; i < 5; i++)
    begin
      u_host.wr(`DCL_REG_CLOCK, 32'h0000_1000 | (32'(i % 4) << 8) | 32'(FIN[i]));
      u_host.upd();
      cyc(6);
      check("factor", 32'(mult_factor), 32'(FEX[i]));
      check("enable", 32'(mult_enable), 32'(i != 0));
      check("gain", 32'(oscillator_gain_range), 32'(i != 0));
      check("pump", 32'(pump_current_select), 32'(i % 4));
    end
    $display("t_clock done");
  endtask : t_clock
  task t_read;
    u_host.rd(`DCL_REG_CLOCK, rv);
    check("clock read", rv, 32'h0000_1019);
    u_host.wr(`DCL_REG_CLOCK, 32'h0000_0004);
    u_host.rd(`DCL_REG_CLOCK, rv);
    check("active read", rv, 32'h0000_1019);
    u_host.rd(`DCL_REG_STATUS, rv);
    check("status read", rv, 32'h0000_1403);
    u_host.rd(4'h5, rv);
    check("unmapped", rv, 32'h0000_0000);
    $display("t_read done");
  endtask : t_read
  task t_clear;
    int cnt;
    u_host.wr(`DCL_REG_FUNC_ONE, 32'h0000_000C);
    u_host.upd();
    cyc(16);
    check("clear hold", 32'(phase_acc_clear), 32'h1);
    check("sweep hold", 32'(sweep_acc_clear), 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      u_host.wr(`DCL_REG_FUNC_ONE, 32'h0000_0000);
      u_host.upd();
      cyc(8);
      u_host.wr(`DCL_REG_FUNC_ONE, 32'h1 << k);
      u_host.upd();
      cnt = 0;
      repeat (10)
      begin
        cyc(1);
        cnt += (k == 0) ? int'(phase_acc_clear) : int'(sweep_acc_clear);
      end
      check("autoclear", 32'(cnt), 32'h1);
    end
    $display("t_clear done");
  endtask : t_clear
  task t_power;
    for (int m = 0; m < 2; m++)
    begin
      u_host.wr(`DCL_REG_PWR, m == 0 ? 32'h0000_0007 : 32'h0000_0010);
      u_host.upd();
      cyc(6);
      check("sw pd", 32'({pd_clock_input, pd_dac_ref, pd_sync_clock_output}),
            m == 0 ? 32'h7 : 32'h0);
      u_host.pin(1'b1);
      cyc(2);
      check("pd dig", 32'(pd_digital), 32'h1);
      check("pd all", 32'(pd_all), 32'(m));
      u_host.pin(1'b0);
      cyc(2);
      check("pd up", 32'(pd_digital), 32'h0);
      check("pd all up", 32'(pd_all), 32'h0);
    end
    $display("t_power done");
  endtask : t_power
  // Main sequence after four reset cycles
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    t_reset();
    t_func();
    t_clock();
    t_read();
    t_clear();
    t_power();
    final_report();
  end
  // Hang guard, well above the expected run
  initial
  begin
    #100000;
    n_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    final_report();
  end
endmodule : test_dds_chip_level_control

// file: verilog/dcl_chip_ctrl.sv
// Purpose: Chip-wide control of a two-channel synthesizer: buffered
//          registers, clock path, accumulator clears, modulation, power-down
// Assumes: Host writes the buffer, pulses io_update, drives powerdown_input
// Notes:   Readback returns active registers, not the holding buffer
// Operation
// - Writes held until update strobe
// - Host reads back configuration registers
// - Multiplier factor four to twenty
// - Disabled multiplier bypasses, ref drives core
// - Core clock is ref times factor
// - Pump current selectable, default 75 uA
// - Reference at most 500 MHz
// - Autoclear zeroes accumulator then resumes
// - Clear holds accumulator at zero
// - Profile pin bits at 14:12, reset zero
// - Ramp source select, default disabled
// - Two to sixteen level modulation
// - Software power-down bits after load
// - Pin power-down: digital or full
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "dcl_params.svh"
module dcl_chip_ctrl (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic [`DCL_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [31:0]            rdata,
  input  wire logic                   io_update,
  input  wire logic                   powerdown_input,
  output logic                        mult_enable,
  output logic      [4:0]             mult_factor,
  output logic      [1:0]             pump_current_select,
  output logic                        oscillator_gain_range,
  output logic      [2:0]             profile_pin_config_bits,
  output dcl_pkg::dcl_ramp_t          amplitude_ramp_control,
  output dcl_pkg::dcl_level_t         mod_level,
  output logic                        phase_acc_clear,
  output logic                        sweep_acc_clear,
  output logic                        pd_clock_input,
  output logic                        pd_dac_ref,
  output logic                        pd_sync_clock_output,
  output logic                        pd_digital,
  output logic                        pd_all
);
  dcl_mem_if mif ();

  // Active registers
  logic [31:0] func_one_r;
  logic [31:0] clock_r;
  logic [31:0] pwr_r;
  logic [1:0]  commit_idx_r;
  logic        committing_r;
  logic        upd_d_r;
  logic        auto_ph_r;
  logic        auto_sw_r;
  dcl_pkg::dcl_pstate_t pstate_r;
  dcl_pkg::dcl_pstate_t pstate_nxt;

  // Output flops
  logic [31:0] rdata_r;
  logic        ph_clr_r;
  logic        sw_clr_r;
  logic        pd_dig_r;
  logic        pd_all_r;

  // Flag a word address that names one of the three buffered registers
  function automatic logic is_cfg(input logic [`DCL_ADDR_W-1:0] a);
    return (a == `DCL_REG_FUNC_ONE) || (a == `DCL_REG_CLOCK) || (a == `DCL_REG_PWR);
  endfunction : is_cfg

  // Clamp a requested factor into the legal range
  function automatic logic [4:0] legal_factor(input logic [4:0] f);
    logic [4:0] g;
    g = f;
    if (f < `DCL_MULT_MIN)
      g = `DCL_MULT_MIN;
    else if (f > `DCL_MULT_MAX)
      g = `DCL_MULT_MAX;
    return g;
  endfunction : legal_factor

  // Buffer port: writes go to holding store only
  assign mif.we    = wr_stb && is_cfg(addr);
  assign mif.waddr = addr;
  assign mif.wdata = wdata;
  assign mif.raddr = {{(`DCL_ADDR_W-2){1'b0}}, commit_idx_r}; // Only the commit walk reads

  dcl_hold_mem u_hold (
    .clk     (clk),
    .reset_n (reset_n),
    .mp      (mif)
  );

  // Field decode of the active registers
  wire [4:0] fact_req  = clock_r[`DCL_CK_MULT_HI:`DCL_CK_MULT_LO];
  wire       mult_on   = (fact_req != `DCL_MULT_OFF);
  wire       mult_bad  = mult_on && ((fact_req < `DCL_MULT_MIN) || (fact_req > `DCL_MULT_MAX));
  wire [4:0] fact_eff  = mult_on ? legal_factor(fact_req) : `DCL_FACT_ONE;
  wire       upd_rise  = io_update && !upd_d_r;
  wire       full_mode = pwr_r[`DCL_PW_FULLMODE];
  wire [31:0] status_w = {19'h0_0000, fact_eff, 4'h0, pd_all_r, pd_dig_r, mult_bad, mult_on};

  // Update strobe edge detect; idle level low, so no false edge after reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      upd_d_r <= 1'b0;
    end
    else
    begin
      upd_d_r <= io_update;
    end
  end

  // Commit sequencer: strobe sampled on clk, words walk out of the buffer.
  // The buffer has one read port, so the copy takes a few cycles but the
  // active set only changes together, on the last of them.
  logic [31:0] stage_f1_r;
  logic [31:0] stage_ck_r;
  logic        apply_r;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      committing_r <= 1'b0;
      commit_idx_r <= 2'h0;
      apply_r      <= 1'b0;
    end
    else
    begin
      if (upd_rise && !committing_r)
      begin
        committing_r <= 1'b1;
        commit_idx_r <= 2'h0;
      end
      else if (committing_r)
      begin
        commit_idx_r <= commit_idx_r + 2'h1;
        if (commit_idx_r == `DCL_CMT_LAST)
          committing_r <= 1'b0;
      end
      apply_r <= committing_r && (commit_idx_r == `DCL_CMT_LAST);
    end
  end

  // Stage words as they leave the buffer, one per cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      stage_f1_r <= `DCL_RST_WORD;
      stage_ck_r <= `DCL_RST_WORD;
    end
    else
    begin
      if (committing_r && commit_idx_r == `DCL_CMT_F1)
        stage_f1_r <= mif.rdata;
      if (committing_r && commit_idx_r == `DCL_CMT_LAST)
        stage_ck_r <= mif.rdata;
    end
  end

  // Single-cycle transfer of the whole set into the active registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      func_one_r <= `DCL_RST_WORD;
      clock_r    <= `DCL_RST_WORD;
      pwr_r      <= `DCL_RST_WORD;
    end
    else if (apply_r)
    begin
      func_one_r <= stage_f1_r;
      clock_r    <= stage_ck_r;
      pwr_r      <= mif.rdata;
    end
  end

  // Autoclear pulses once per commit in which its bit is set
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      auto_ph_r <= 1'b0;
      auto_sw_r <= 1'b0;
    end
    else
    begin
      auto_ph_r <= apply_r && stage_f1_r[`DCL_F1_AUTO_PH];
      auto_sw_r <= apply_r && stage_f1_r[`DCL_F1_AUTO_SW];
    end
  end

  // Accumulator clear outputs: hold while set, one pulse for autoclear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ph_clr_r <= 1'b0;
      sw_clr_r <= 1'b0;
    end
    else
    begin
      ph_clr_r <= func_one_r[`DCL_F1_CLR_PH] || auto_ph_r;
      sw_clr_r <= func_one_r[`DCL_F1_CLR_SW] || auto_sw_r;
    end
  end

  // Pin power-down state; pin high requests power-down
  always_comb
  begin
    pstate_nxt = dcl_pkg::DCL_PS_UP;
    case (pstate_r)
      dcl_pkg::DCL_PS_UP:
        if (powerdown_input)
          pstate_nxt = full_mode ? dcl_pkg::DCL_PS_FULL : dcl_pkg::DCL_PS_DIG;
      dcl_pkg::DCL_PS_DIG,
      dcl_pkg::DCL_PS_FULL:
        if (!powerdown_input)
          pstate_nxt = dcl_pkg::DCL_PS_UP;
        else
          pstate_nxt = pstate_r;
      default:
        pstate_nxt = dcl_pkg::DCL_PS_UP;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pstate_r <= dcl_pkg::DCL_PS_UP;
      pd_dig_r <= 1'b0;
      pd_all_r <= 1'b0;
    end
    else
    begin
      pstate_r <= pstate_nxt;
      pd_dig_r <= (pstate_nxt != dcl_pkg::DCL_PS_UP);
      pd_all_r <= (pstate_nxt == dcl_pkg::DCL_PS_FULL);
    end
  end

  // Readback: active registers answer directly, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdata_r   <= `DCL_RST_WORD;
    end
    else
    begin
      if (rd_stb)
      begin
        case (addr)
          `DCL_REG_FUNC_ONE: rdata_r <= func_one_r;
          `DCL_REG_CLOCK:    rdata_r <= clock_r;
          `DCL_REG_PWR:      rdata_r <= pwr_r;
          `DCL_REG_STATUS:   rdata_r <= status_w;
          default:           rdata_r <= `DCL_RST_WORD;
        endcase
      end
      else
        rdata_r <= `DCL_RST_WORD;
    end
  end

  // Clock path fields, decoded on the active clock register
  logic        mult_en_r;
  logic [4:0]  fact_r;
  logic [1:0]  pump_r;
  logic        gain_r;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mult_en_r <= 1'b0;
      fact_r    <= `DCL_FACT_ONE;
      pump_r    <= `DCL_PUMP_75UA;
      gain_r    <= 1'b0;
    end
    else
    begin
      mult_en_r <= mult_on;
      fact_r    <= fact_eff;
      pump_r    <= clock_r[`DCL_CK_PUMP_HI:`DCL_CK_PUMP_LO];
      gain_r    <= clock_r[`DCL_CK_GAIN] && mult_on;
    end
  end

  // Modulation fields; all leave reset at zero, ramp control disabled
  logic [2:0]  ppc_r;
  logic [1:0]  ramp_r;
  logic [1:0]  level_r;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ppc_r     <= 3'h0;
      ramp_r    <= 2'h0;
      level_r   <= 2'h0;
    end
    else
    begin
      ppc_r     <= func_one_r[`DCL_F1_PPC_HI:`DCL_F1_PPC_LO];
      ramp_r    <= func_one_r[`DCL_F1_RAMP_HI:`DCL_F1_RAMP_LO];
      level_r   <= func_one_r[`DCL_F1_LEVEL_HI:`DCL_F1_LEVEL_LO];
    end
  end

  // Software power-down bits act only once a commit has loaded them
  logic [2:0]  swpd_r;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      swpd_r    <= 3'h0;
    end
    else
    begin
      swpd_r    <= {pwr_r[`DCL_PW_SYNCOUT], pwr_r[`DCL_PW_DACREF], pwr_r[`DCL_PW_CLKIN]};
    end
  end

  // Port drive
  assign rdata                   = rdata_r;
  assign mult_enable             = mult_en_r;
  assign mult_factor             = fact_r;
  assign pump_current_select     = pump_r;
  assign oscillator_gain_range   = gain_r;
  assign profile_pin_config_bits = ppc_r;
  assign amplitude_ramp_control  = dcl_pkg::dcl_ramp_t'(ramp_r);
  assign mod_level               = dcl_pkg::dcl_level_t'(level_r);
  assign phase_acc_clear         = ph_clr_r;
  assign sweep_acc_clear         = sw_clr_r;
  assign pd_clock_input          = swpd_r[0];
  assign pd_dac_ref              = swpd_r[1];
  assign pd_sync_clock_output    = swpd_r[2];
  assign pd_digital              = pd_dig_r;
  assign pd_all                  = pd_all_r;
endmodule : dcl_chip_ctrl

// file: verilog/dcl_hold_mem.sv
// Purpose: Holding buffer for host register writes awaiting the update strobe
// Assumes: Synchronous reset, registered read data
// Notes:   Read data appear the cycle after the read address
`timescale 1ns/1ps
`include "dcl_params.svh"
module dcl_hold_mem (
  input  wire logic clk,
  input  wire logic reset_n,
  dcl_mem_if.mem    mp
);
  logic [31:0] words_r [0:`DCL_NREG-1];
  logic [31:0] rdata_r;

  // Store and registered read
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < `DCL_NREG; i++)
        words_r[i] <= `DCL_RST_WORD;
      rdata_r <= `DCL_RST_WORD;
    end
    else
    begin
      if (mp.we)
        words_r[mp.waddr[1:0]] <= mp.wdata;
      rdata_r <= words_r[mp.raddr[1:0]];
    end
  end

  assign mp.rdata = rdata_r;
endmodule : dcl_hold_mem
